// ---- rtl/framer_consts.svh ----
// named constants of the strobe framer: bus offsets, reset values, widths
// assumes inclusion by bare name from every framer design file
`ifndef FRAMER_CONSTS_SVH
`define FRAMER_CONSTS_SVH

// bus and word geometry
`define NUM_BUSES 4
`define WORD_W 12
`define LEN_W 8
`define PAIR_BUSES 2

// register byte offsets
`define ADR_LINK_CTRL 8'h00
`define ADR_PATTERN 8'h04
`define ADR_FRAME_LEN 8'h08
`define ADR_CS_EN 8'h0C
`define ADR_STATUS 8'h10

// writable bits of each register
`define MASK_LINK_CTRL 32'h0000_007F
`define MASK_PATTERN 32'h0000_0003
`define MASK_FRAME_LEN 32'h0000_00FF
`define MASK_CS_EN 32'h0000_00FF

// reset values: sync from pin, frame of eight, two-bus mode, all enable bits set
`define RST_LINK_CTRL 32'h0000_0002
`define RST_PATTERN 2'h0
`define RST_FRAME_LEN 8'h08
`define RST_CS_EN 32'h0000_00FF

// fixed words of the all-pairs pattern
`define WORD_ZERO 12'h000
`define WORD_ONES 12'hFFF

`endif

// ---- rtl/framer_pkg.sv ----
// types shared by the strobe framer: register layouts, lane bundle, state
// assumes framer_consts.svh is available on the include path
`include "framer_consts.svh"

package framer_pkg;
    typedef logic [`WORD_W-1:0] word_t;

    typedef enum logic [1:0] {
        SYNC_FROM_REG = 2'h0,
        SYNC_FROM_PIN = 2'h1,
        SYNC_FROM_STAMP = 2'h2,
        SYNC_FROM_NONE = 2'h3
    } sync_src_t;

    typedef enum logic [1:0] {
        STB_FROM_GEN = 2'h0,
        STB_FROM_STAMP = 2'h1,
        STB_FROM_SYSREF = 2'h2,
        STB_FROM_OFF = 2'h3
    } stb_src_t;

    typedef enum logic [1:0] {
        PAT_NORMAL = 2'h0,
        PAT_SPARE = 2'h1,
        PAT_LSB = 2'h2,
        PAT_ALL = 2'h3
    } pattern_t;

    typedef struct packed {
        logic [24:0] reserved;
        logic busDemux;
        logic syncBit;
        stb_src_t strobeSource;
        sync_src_t syncSource;
        logic scrambleEnable;
    } link_ctrl_t;

    typedef struct packed {
        logic [23:0] reserved;
        logic [`NUM_BUSES-1:0] dataClockEnable;
        logic [`NUM_BUSES-1:0] strobeEnable;
    } cs_en_t;

    typedef struct packed {
        word_t data;
        logic strobe;
        logic strobeOn;
        logic clock;
        logic clockOn;
    } lane_t;

    typedef struct packed {
        link_ctrl_t linkCtrl;
        pattern_t pattern;
        logic [`LEN_W-1:0] frameLen;
        cs_en_t csEn;
        logic [31:0] datRd;
        logic ack;
        logic err;
        lane_t [`NUM_BUSES-1:0] lanes;
    } framer_state_t;

    typedef struct packed {
        logic [`LEN_W-1:0] pos;
        logic phase;
    } gen_state_t;

    // memoryless xor scrambler of one 12-bit sample
    function automatic word_t scramble(input word_t d);
        word_t y;
        y = d ^ {`WORD_W{d[1] ^ d[0]}};
        y[1] = d[1];
        y[0] = d[0] ^ d[1];
        return y;
    endfunction : scramble
endpackage : framer_pkg

// ---- rtl/frame_strobe_gen.sv ----
// frame position counter and ddr clock phase divider
// assumes sysref is a synchronous pulse in the sys_clk domain
`include "framer_consts.svh"

module frame_strobe_gen (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // frame control
    input wire logic sysref,
    input wire logic [`LEN_W-1:0] frameLen,
    // frame state
    output logic [`LEN_W-1:0] framePos,
    output logic endOfFrame,
    output logic clockPhase
);
    framer_pkg::gen_state_t s_q;
    framer_pkg::gen_state_t s_d;
    logic [`LEN_W-1:0] lastUi;

    assign lastUi = (frameLen == '0) ? '0 : frameLen - `LEN_W'(1);
    assign framePos = s_q.pos;
    assign endOfFrame = (s_q.pos == lastUi);
    assign clockPhase = s_q.phase;

    always_comb begin
        s_d = s_q;
        if (sysref) begin
            s_d.pos = '0;
            s_d.phase = 1'b0;
        end else begin
            s_d.phase = !s_q.phase;
            if (s_q.pos >= lastUi) begin
                s_d.pos = '0;
            end else begin
                s_d.pos = s_q.pos + `LEN_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : frame_strobe_gen

// ---- rtl/bus_word_encoder.sv ----
// per-bus pattern substitution and scrambling, purely combinational
// assumes the caller registers both outputs
`include "framer_consts.svh"

module bus_word_encoder (
    // sample and frame marker
    input framer_pkg::word_t sample,
    input wire logic frameStrobe,
    // mode
    input wire logic syncActive,
    input framer_pkg::pattern_t pattern,
    input wire logic scrambleOn,
    // encoded outputs
    output framer_pkg::word_t word,
    output logic strobeLine
);
    framer_pkg::word_t plain;

    always_comb begin
        plain = sample;
        if (syncActive && pattern == framer_pkg::PAT_LSB) begin
            plain[0] = frameStrobe;
        end else if (syncActive && pattern == framer_pkg::PAT_ALL) begin
            plain = frameStrobe ? `WORD_ONES : `WORD_ZERO;
        end
        if (scrambleOn) begin
            word = framer_pkg::scramble(plain);
            strobeLine = frameStrobe ^ plain[1] ^ plain[0];
        end else begin
            word = plain;
            strobeLine = frameStrobe;
        end
    end
endmodule : bus_word_encoder

// ---- rtl/lvds_strobe_framer.sv ----
// output framer of a four-bus lvds sample interface with frame strobes
// assumes samples, sysref, timestamp and sync pin are synchronous to sys_clk,
// one unit interval per sys_clk cycle, and a classic wishbone master
//
// Overview of operation
// - four 12-bit buses, each with its own ddr data clock and strobe
// - strobe taken from generator, timestamp copy or sysref copy
// - scrambling off by default; then samples pass unchanged
// - sysref resets clock divider and strobe generator
// - strobe low on every unit interval except the last of a frame
// - frame length comes from a writable field; strobe repeats with it
// - sysref starts a new frame at unit interval zero
// - strobe shares data timing, source-synchronous with its bus clock
// - sync gate source selectable: register bit, sync pin or timestamp
// - dedicated mode keeps all 12 bits, strobe on its own pair
// - dedicated strobe runs whatever the sync gate does
// - buses c and d may drop clock and strobe, reusing a and b
// - lsb pattern: while synced the lsb carries the strobe
// - sync pin is the default sync gate source
// - all-pairs pattern: words 0x000, last unit interval 0xFFF
// - enabled strobe pairs keep the strobe in all-pairs mode
// - 12-bit scrambler uses only the current sample
// - per-bus enables turn off unused strobes and data clocks
// - demux setting selects two or four active buses
`include "framer_consts.svh"

module lvds_strobe_framer (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // wishbone register slave
    input wire logic [7:0] adr,
    input wire logic [31:0] datWr,
    input wire logic [3:0] sel,
    input wire logic we,
    input wire logic cyc,
    input wire logic stb,
    output logic [31:0] datRd,
    output logic ack,
    output logic err,
    // sample stream and timing inputs
    input framer_pkg::word_t [`NUM_BUSES-1:0] samples,
    input wire logic sysref,
    input wire logic timestampIn,
    input wire logic syncPin,
    // lvds bus lanes
    output framer_pkg::lane_t [`NUM_BUSES-1:0] lanes
);
    framer_pkg::framer_state_t s_q;
    framer_pkg::framer_state_t s_d;
    logic [`LEN_W-1:0] framePos;
    logic endOfFrame;
    logic clockPhase;
    logic frameStrobe;
    logic syncActive;
    logic reqNew;
    logic writeNow;
    logic addrHit;
    logic [31:0] readMux;
    framer_pkg::word_t [`NUM_BUSES-1:0] encWord;
    logic [`NUM_BUSES-1:0] encStrobe;
    logic [`NUM_BUSES-1:0] busActive;

    // byte-lane merge of a write into a register image
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr,
                                          input logic [3:0] be, input logic [31:0] mask);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wr[b*8 +: 8];
            end
        end
        return r & mask;
    endfunction : merge

    frame_strobe_gen u_gen (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .sysref(sysref),
        .frameLen(s_q.frameLen),
        .framePos(framePos),
        .endOfFrame(endOfFrame),
        .clockPhase(clockPhase)
    );

    // strobe source and sync gate selection
    always_comb begin
        unique case (s_q.linkCtrl.strobeSource)
            framer_pkg::STB_FROM_GEN: frameStrobe = endOfFrame;
            framer_pkg::STB_FROM_STAMP: frameStrobe = timestampIn;
            framer_pkg::STB_FROM_SYSREF: frameStrobe = sysref;
            default: frameStrobe = 1'b0;
        endcase
        unique case (s_q.linkCtrl.syncSource)
            framer_pkg::SYNC_FROM_REG: syncActive = s_q.linkCtrl.syncBit;
            framer_pkg::SYNC_FROM_PIN: syncActive = syncPin;
            framer_pkg::SYNC_FROM_STAMP: syncActive = timestampIn;
            default: syncActive = 1'b0;
        endcase
    end

    for (genvar g = 0; g < `NUM_BUSES; g++) begin : g_bus
        bus_word_encoder u_enc (
            .sample(samples[g]),
            .frameStrobe(frameStrobe),
            .syncActive(syncActive),
            .pattern(s_q.pattern),
            .scrambleOn(s_q.linkCtrl.scrambleEnable),
            .word(encWord[g]),
            .strobeLine(encStrobe[g])
        );
    end

    // c and d carry data only when demuxed
    always_comb begin
        for (int i = 0; i < `NUM_BUSES; i++) begin
            busActive[i] = (i < `PAIR_BUSES) || s_q.linkCtrl.busDemux;
        end
    end

    // register decode
    assign reqNew = cyc && stb && !s_q.ack && !s_q.err;
    assign writeNow = cyc && stb && we && s_q.ack;

    always_comb begin
        addrHit = 1'b1;
        readMux = '0;
        unique case (adr)
            `ADR_LINK_CTRL: readMux = s_q.linkCtrl;
            `ADR_PATTERN: readMux = {30'h0000_0000, s_q.pattern};
            `ADR_FRAME_LEN: readMux = {24'h00_0000, s_q.frameLen};
            `ADR_CS_EN: readMux = s_q.csEn;
            `ADR_STATUS: readMux = {22'h00_0000, clockPhase, syncActive, framePos};
            default: addrHit = 1'b0;
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.err = 1'b0;
        if (reqNew) begin
            s_d.ack = addrHit;
            s_d.err = !addrHit;
            s_d.datRd = addrHit ? readMux : '0;
        end
        if (writeNow) begin
            unique case (adr)
                `ADR_LINK_CTRL: s_d.linkCtrl = merge(s_q.linkCtrl, datWr, sel,
                                                     `MASK_LINK_CTRL);
                `ADR_PATTERN: s_d.pattern = framer_pkg::pattern_t'(2'(merge(
                    {30'h0000_0000, s_q.pattern}, datWr, sel, `MASK_PATTERN)));
                `ADR_FRAME_LEN: s_d.frameLen = `LEN_W'(merge({24'h00_0000, s_q.frameLen},
                                                          datWr, sel, `MASK_FRAME_LEN));
                `ADR_CS_EN: s_d.csEn = merge(s_q.csEn, datWr, sel, `MASK_CS_EN);
                default: ;
            endcase
        end
        for (int i = 0; i < `NUM_BUSES; i++) begin
            s_d.lanes[i].data = busActive[i] ? encWord[i] : `WORD_ZERO;
            s_d.lanes[i].strobeOn = busActive[i] && s_q.csEn.strobeEnable[i];
            s_d.lanes[i].strobe = busActive[i] && s_q.csEn.strobeEnable[i]
                                  && encStrobe[i];
            s_d.lanes[i].clockOn = busActive[i] && s_q.csEn.dataClockEnable[i];
            s_d.lanes[i].clock = busActive[i] && s_q.csEn.dataClockEnable[i]
                                 && clockPhase;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
            s_q.linkCtrl <= `RST_LINK_CTRL;
            s_q.pattern <= framer_pkg::pattern_t'(`RST_PATTERN);
            s_q.frameLen <= `RST_FRAME_LEN;
            s_q.csEn <= `RST_CS_EN;
        end else begin
            s_q <= s_d;
        end
    end

    assign datRd = s_q.datRd;
    assign ack = s_q.ack;
    assign err = s_q.err;
    assign lanes = s_q.lanes;

    // checks of the frame and output behaviour
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    logic [`LEN_W-1:0] lastUiChk;
    assign lastUiChk = (s_q.frameLen == '0) ? '0 : s_q.frameLen - `LEN_W'(1);

    property p_sysref_restart;
        sysref |=> (framePos == '0) && !clockPhase;
    endproperty
    a_sysref_restart: assert property (p_sysref_restart)
        else $error("frame did not restart after sysref");

    property p_frame_wrap;
        !sysref && (framePos == lastUiChk) |=> (framePos == '0);
    endproperty
    a_frame_wrap: assert property (p_frame_wrap)
        else $error("frame counter did not wrap at last unit interval");

    property p_frame_advance;
        resetn && !sysref && (framePos < lastUiChk)
            |=> (framePos == $past(framePos) + `LEN_W'(1));
    endproperty
    a_frame_advance: assert property (p_frame_advance)
        else $error("frame counter did not advance by one");

    property p_dedicated_strobe;
        (s_q.linkCtrl.strobeSource == framer_pkg::STB_FROM_GEN) && s_q.csEn.strobeEnable[0]
            && !s_q.linkCtrl.scrambleEnable
            |=> (lanes[0].strobe == ($past(framePos) == $past(lastUiChk)));
    endproperty
    a_dedicated_strobe: assert property (p_dedicated_strobe)
        else $error("dedicated strobe not high exactly at last unit interval");

    property p_lsb_replace;
        syncActive && (s_q.pattern == framer_pkg::PAT_LSB) && !s_q.linkCtrl.scrambleEnable
            |=> (lanes[0].data == {$past(samples[0][11:1]), $past(frameStrobe)});
    endproperty
    a_lsb_replace: assert property (p_lsb_replace)
        else $error("lsb not replaced by frame strobe");

    property p_all_pairs;
        syncActive && (s_q.pattern == framer_pkg::PAT_ALL) && !s_q.linkCtrl.scrambleEnable
            |=> (lanes[1].data == ($past(frameStrobe) ? `WORD_ONES : `WORD_ZERO));
    endproperty
    a_all_pairs: assert property (p_all_pairs)
        else $error("all-pairs pattern word wrong");

    property p_plain_pass;
        resetn && (!syncActive || s_q.pattern < framer_pkg::PAT_LSB)
            && !s_q.linkCtrl.scrambleEnable |=> (lanes[0].data == $past(samples[0]));
    endproperty
    a_plain_pass: assert property (p_plain_pass)
        else $error("sample not passed unmodified");

    property p_scramble;
        s_q.linkCtrl.scrambleEnable && (s_q.pattern == framer_pkg::PAT_NORMAL)
            |=> (lanes[1].data == framer_pkg::scramble($past(samples[1])));
    endproperty
    a_scramble: assert property (p_scramble)
        else $error("scrambled word wrong");

    property p_outputs_off;
        !s_q.csEn.dataClockEnable[3] && !s_q.csEn.strobeEnable[3]
            |=> !lanes[3].clock && !lanes[3].strobe && !lanes[3].clockOn;
    endproperty
    a_outputs_off: assert property (p_outputs_off)
        else $error("disabled clock or strobe still active");

    property p_two_bus;
        !s_q.linkCtrl.busDemux |=> (lanes[2].data == `WORD_ZERO) && !lanes[2].clockOn;
    endproperty
    a_two_bus: assert property (p_two_bus)
        else $error("bus c active in two-bus mode");

    property p_phase_toggle;
        resetn && !sysref |=> (clockPhase != $past(clockPhase));
    endproperty
    a_phase_toggle: assert property (p_phase_toggle)
        else $error("clock phase did not toggle");

    property p_lane_clock;
        resetn && s_q.csEn.dataClockEnable[0] |=> (lanes[0].clock == $past(clockPhase));
    endproperty
    a_lane_clock: assert property (p_lane_clock)
        else $error("bus a clock out of phase");

    property p_stamp_strobe;
        resetn && (s_q.linkCtrl.strobeSource == framer_pkg::STB_FROM_STAMP)
            && s_q.csEn.strobeEnable[0] && !s_q.linkCtrl.scrambleEnable
            |=> (lanes[0].strobe == $past(timestampIn));
    endproperty
    a_stamp_strobe: assert property (p_stamp_strobe)
        else $error("strobe not a timestamp copy");

    property p_sysref_strobe;
        resetn && (s_q.linkCtrl.strobeSource == framer_pkg::STB_FROM_SYSREF)
            && s_q.csEn.strobeEnable[0] && !s_q.linkCtrl.scrambleEnable
            |=> (lanes[0].strobe == $past(sysref));
    endproperty
    a_sysref_strobe: assert property (p_sysref_strobe)
        else $error("strobe not a sysref copy");

    property p_strobe_unsynced;
        resetn && (s_q.linkCtrl.strobeSource == framer_pkg::STB_FROM_GEN) && !syncActive
            && s_q.csEn.strobeEnable[1] && !s_q.linkCtrl.scrambleEnable
            |=> (lanes[1].strobe == ($past(framePos) == $past(lastUiChk)));
    endproperty
    a_strobe_unsynced: assert property (p_strobe_unsynced)
        else $error("dedicated strobe gated by sync");

    property p_all_pairs_strobe;
        resetn && (s_q.linkCtrl.strobeSource == framer_pkg::STB_FROM_GEN) && syncActive
            && (s_q.pattern == framer_pkg::PAT_ALL) && s_q.csEn.strobeEnable[0]
            && !s_q.linkCtrl.scrambleEnable
            |=> (lanes[0].strobe == ($past(framePos) == $past(lastUiChk)));
    endproperty
    a_all_pairs_strobe: assert property (p_all_pairs_strobe)
        else $error("strobe pair lost in all-pairs mode");

    property p_scramble_strobe;
        resetn && s_q.linkCtrl.scrambleEnable && (s_q.pattern == framer_pkg::PAT_NORMAL)
            && (s_q.linkCtrl.strobeSource == framer_pkg::STB_FROM_GEN)
            && s_q.csEn.strobeEnable[0]
            |=> (lanes[0].strobe == (($past(framePos) == $past(lastUiChk))
                ^ $past(samples[0][1]) ^ $past(samples[0][0])));
    endproperty
    a_scramble_strobe: assert property (p_scramble_strobe)
        else $error("scrambled strobe wrong");

    property p_bus_d_strobe;
        resetn && s_q.linkCtrl.busDemux && s_q.csEn.strobeEnable[3]
            && (s_q.linkCtrl.strobeSource == framer_pkg::STB_FROM_GEN)
            && !s_q.linkCtrl.scrambleEnable
            |=> (lanes[3].strobe == ($past(framePos) == $past(lastUiChk)));
    endproperty
    a_bus_d_strobe: assert property (p_bus_d_strobe)
        else $error("bus d strobe wrong");

    property p_two_bus_d;
        resetn && !s_q.linkCtrl.busDemux
            |=> !lanes[3].strobeOn && !lanes[3].clockOn && (lanes[3].data == `WORD_ZERO);
    endproperty
    a_two_bus_d: assert property (p_two_bus_d)
        else $error("bus d active in two-bus mode");

    property p_reg_sync_bit;
        resetn && (s_q.linkCtrl.syncSource == framer_pkg::SYNC_FROM_REG)
            && s_q.linkCtrl.syncBit && (s_q.pattern == framer_pkg::PAT_LSB)
            && s_q.csEn.strobeEnable[1] && !s_q.linkCtrl.scrambleEnable
            |=> (lanes[1].data[0] == lanes[1].strobe);
    endproperty
    a_reg_sync_bit: assert property (p_reg_sync_bit)
        else $error("register sync bit did not gate the strobe");
endmodule : lvds_strobe_framer

// ---- dv/lvds_rx_model.sv ----
// receiver model of the far end: captures each bus, descrambles, aligns
// assumes one unit interval per sys_clk cycle, lanes sampled at each rising edge
`include "framer_consts.svh"

module lvds_rx_model (
    // clock
    input wire logic sys_clk,
    // lanes and receiver setting
    input framer_pkg::lane_t [`NUM_BUSES-1:0] lanes,
    input wire logic descrambleOn,
    // recovered stream
    output framer_pkg::word_t [`NUM_BUSES-1:0] rxWord,
    output logic [`NUM_BUSES-1:0] rxStrobe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [`NUM_BUSES-1:0][7:0] uiCount;

    always @(posedge sys_clk) begin
        for (int b = 0; b < `NUM_BUSES; b++) begin
            framer_pkg::word_t y;
            logic s;
            y = lanes[b].data;
            // c and d borrow the strobe of a and b when theirs is off
            s = lanes[b].strobeOn ? lanes[b].strobe : lanes[b % 2].strobe;
            // undo the xor scrambling
            if (descrambleOn) begin
                s = s ^ y[0];
                y = y ^ {`WORD_W{y[0]}};
                y[1] = lanes[b].data[1];
                y[0] = lanes[b].data[0] ^ lanes[b].data[1];
            end
            rxWord[b] <= y;
            rxStrobe[b] <= s;
            // capture alignment restarts after each strobe
            uiCount[b] <= s ? 8'h00 : uiCount[b] + 8'h01;
        end
    end
endmodule : lvds_rx_model

// ---- dv/lvds_strobe_framer_bench.sv ----
// self-checking bench of the strobe framer: registers, strobes, patterns
// assumes a 250 MHz sys_clk and the receiver model beside the lanes
`include "framer_consts.svh"

module lvds_strobe_framer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, resetn, we, cyc, stb, sysref, timestampIn, syncPin, ack, err, e;
    logic [7:0] adr;
    logic [31:0] datWr, datRd, q, cfgLink, cfgCs;
    logic [3:0] sel;
    logic [1:0] cfgPat;
    framer_pkg::word_t [`NUM_BUSES-1:0] samples, rxWord;
    logic [`NUM_BUSES-1:0] rxStrobe;
    framer_pkg::lane_t [`NUM_BUSES-1:0] lanes;
    int err_total, n_checks, len, spMode, sr2;

    lvds_strobe_framer dut (.sys_clk(sys_clk), .resetn(resetn), .adr(adr), .datWr(datWr),
        .sel(sel), .we(we), .cyc(cyc), .stb(stb), .datRd(datRd), .ack(ack), .err(err),
        .samples(samples), .sysref(sysref), .timestampIn(timestampIn), .syncPin(syncPin),
        .lanes(lanes));
    lvds_rx_model rx (.sys_clk(sys_clk), .lanes(lanes), .descrambleOn(cfgLink[0]),
        .rxWord(rxWord), .rxStrobe(rxStrobe));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic framer_pkg::word_t smp(input int c, input int b);
        return framer_pkg::word_t'(c * 12'h2B7 + b * 12'h15D + 12'h0A3);
    endfunction : smp

    function automatic framer_pkg::word_t scramble_enable(input framer_pkg::word_t d);
        framer_pkg::word_t y;
        for (int k = 2; k < 12; k++) y[k] = d[k] ^ d[1] ^ d[0];
        y[1] = d[1];
        y[0] = d[0] ^ d[1];
        return y;
    endfunction : scramble_enable

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        datWr <= d;
        sel <= 4'hF;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (ack !== 1'b1 && err !== 1'b1 && k < 40);
        q = datRd;
        e = err;
        if (k >= 40) chk(32'h0, 32'h1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
        wb(1'b0, a, 32'h0);
        chk(e, xe);
        chk(q, x);
    endtask : rdc

    task automatic setup(input logic [31:0] lk, input logic [1:0] pt, input int ln);
        cfgLink = lk;
        cfgPat = pt;
        len = ln;
        wb(1'b1, `ADR_LINK_CTRL, lk);
        wb(1'b1, `ADR_PATTERN, {30'h0, pt});
        wb(1'b1, `ADR_FRAME_LEN, ln);
        wb(1'b1, `ADR_CS_EN, cfgCs);
    endtask : setup

    task automatic lanecheck(input int c, input int pos, input logic ph, sr, ts, sp);
        framer_pkg::link_ctrl_t lc;
        framer_pkg::word_t w;
        logic [3:0] v;
        logic sa, st, s, en;
        lc = framer_pkg::link_ctrl_t'(cfgLink);
        v = {1'b0, ts, sp, lc.syncBit};
        sa = v[lc.syncSource];
        v = {1'b0, sr, ts, logic'(pos == len - 1)};
        st = v[lc.strobeSource];
        for (int b = 0; b < 4; b++) begin
            w = smp(c, b);
            if (sa && cfgPat == 2'h2) w[0] = st;
            if (sa && cfgPat == 2'h3) w = st ? `WORD_ONES : `WORD_ZERO;
            s = st ^ (lc.scrambleEnable & (w[1] ^ w[0]));
            if (lc.scrambleEnable) w = scramble_enable(w);
            en = b < 2 || lc.busDemux;
            chk(lanes[b].data, en ? w : `WORD_ZERO);
            chk(lanes[b].strobeOn, en & cfgCs[b]);
            chk(lanes[b].clockOn, en & cfgCs[4 + b]);
            chk(lanes[b].clock, en & cfgCs[4 + b] & ph);
            if (en & cfgCs[b]) chk(lanes[b].strobe, s);
        end
    endtask : lanecheck

    task automatic run(input int n);
        int pPos, cPos, bPos;
        logic pPh, cPh, pSr, cSr, pTs, cTs, pSp, cSp;
        for (int j = 0; j <= n; j++) begin
            @(posedge sys_clk);
            bPos = cPos;
            cPos = pPos;
            cPh = pPh;
            cSr = pSr;
            cTs = pTs;
            cSp = pSp;
            pPos = cSr ? 0 : (cPos + 1) % len;
            pPh = cSr ? 1'b0 : ~cPh;
            pSr = (j == 0 || j == sr2);
            pTs = (j % 3 == 1);
            pSp = spMode == 2 ? (j % 4 > 1) : spMode[0];
            for (int b = 0; b < 4; b++) samples[b] <= smp(j, b);
            sysref <= pSr;
            timestampIn <= pTs;
            syncPin <= pSp;
            #1;
            if (j >= 2) lanecheck(j - 1, cPos, cPh, cSr, cTs, cSp);
            if (j >= 3 && cfgLink[0]) chk(rxWord[1], smp(j - 2, 1));
            if (j >= 3 && cfgLink[0]) chk(rxStrobe[1], logic'(bPos == len - 1));
        end
    endtask : run

    task automatic t_regs;
        rdc(`ADR_LINK_CTRL, `RST_LINK_CTRL, 1'b0);
        rdc(`ADR_PATTERN, 32'h0, 1'b0);
        rdc(`ADR_CS_EN, `RST_CS_EN, 1'b0);
        rdc(`ADR_FRAME_LEN, `RST_FRAME_LEN, 1'b0);
        rdc(8'h14, 32'h0, 1'b1);
        wb(1'b1, `ADR_FRAME_LEN, 32'hFFFF_FF05);
        rdc(`ADR_FRAME_LEN, 32'h5, 1'b0);
    endtask : t_regs

    task automatic t_modes;
        spMode = 0;
        setup(32'h42, 2'h0, 8);
        run(20);
        spMode = 2;
        sr2 = 7;
        setup(32'h42, 2'h2, 5);
        run(24);
        sr2 = 0;
        cfgCs = 32'h33;
        setup(32'h42, 2'h3, 4);
        run(20);
        cfgCs = 32'hFF;
        spMode = 1;
        setup(32'h43, 2'h0, 6);
        run(16);
        setup(32'h68, 2'h2, 8);
        run(16);
        sr2 = 9;
        setup(32'h54, 2'h2, 8);
        run(16);
        sr2 = 0;
        setup(32'h02, 2'h0, 8);
        run(10);
    endtask : t_modes

    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done

    initial begin
        err_total = 0;
        n_checks = 0;
        resetn = 1'b0;
        {cyc, stb, we, sysref, timestampIn, syncPin} = 6'h00;
        adr = 8'h00;
        datWr = 32'h0;
        sel = 4'h0;
        samples = '0;
        cfgLink = `RST_LINK_CTRL;
        cfgCs = 32'hFF;
        cfgPat = 2'h0;
        len = 8;
        spMode = 0;
        sr2 = 0;
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        t_regs();
        t_modes();
        test_done();
    end

    initial begin
        #100000;
        err_total++;
        test_done();
    end
endmodule : lvds_strobe_framer_bench
